/* ctp_timer.sv */
`timescale 1ns/10ps
`include "ctp_defines.svh"

module ctp_timer #(
    parameter int SUB_DIV = `CTP_SUB_DIV
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        event_input_pin_i,
    output logic             pwm_out_n_o,
    output logic             match_overflow_irq_o
);
    logic       rst_a_ff;
    logic       rst_n_ff;
    logic       t1, t3, t5, t7, t11, sub, sub8, evt_fall;
    logic [7:0] lower_control_reg_ff, nxt_lower_control_reg;
    logic [7:0] upper_control_reg_ff, nxt_upper_control_reg;
    logic [1:0] cfg_ff, nxt_cfg;
    logic [15:0] period_ff, nxt_period;
    logic [15:0] duty_buf_ff, nxt_duty_buf;
    logic [15:0] duty_act_ff, nxt_duty_act;
    logic [7:0] cnt_lo_ff, nxt_cnt_lo;
    logic [7:0] cnt_hi_ff, nxt_cnt_hi;
    logic       tff_ff, nxt_tff;
    logic       nxt_irq;
    logic [31:0] nxt_prdata;
    logic       nxt_pready, nxt_pslverr;
    logic       wr, run, pwm, slow, tick, hit, ovf;
    logic [15:0] cnt;
    logic [2:0] sel;

    // reset release through two flip-flops
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_a_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_n_ff <= rst_a_ff;
        end
    end

    ctp_prescaler #(
        .SUB_DIV (SUB_DIV)
    ) u_psc (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n_ff),
        .t1_o    (t1),
        .t3_o    (t3),
        .t5_o    (t5),
        .t7_o    (t7),
        .t11_o   (t11),
        .sub_o   (sub),
        .sub8_o  (sub8)
    );

    ctp_event_sync u_evt (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n_ff),
        .pin_i   (event_input_pin_i),
        .fall_o  (evt_fall)
    );

    // decoded control state
    // run bit and mode, slow and select fields
    assign run  = upper_control_reg_ff[`CTP_UC_RUN_BIT];
    assign pwm  = (upper_control_reg_ff[2:0] == ctp_pkg::CTP_MODE_PWM);
    assign slow = cfg_ff[`CTP_CFG_SLOW_BIT];
    assign sel  = lower_control_reg_ff[`CTP_LC_SEL_LSB +: 3];
    assign cnt  = {cnt_hi_ff, cnt_lo_ff};
    assign wr   = psel_i && penable_i && pwrite_i && pready_o;
    assign hit  = (cnt == period_ff);
    assign ovf  = (cnt == `CTP_CNT_MAX);

    // count tick selection per mode and power state
    always_comb begin
        tick = 1'b0;
        case (sel)
            ctp_pkg::CTP_SEL_DIV11:
                tick = cfg_ff[`CTP_CFG_PSEL_BIT] ? sub8 : t11;
            ctp_pkg::CTP_SEL_DIV7: tick = t7;
            ctp_pkg::CTP_SEL_DIV5: tick = t5;
            ctp_pkg::CTP_SEL_DIV3: tick = t3;
            ctp_pkg::CTP_SEL_SUB:  tick = pwm && sub;
            ctp_pkg::CTP_SEL_DIV1: tick = pwm && t1;
            ctp_pkg::CTP_SEL_MAIN: tick = pwm;
            ctp_pkg::CTP_SEL_EXT:  tick = pwm && evt_fall;
            default:               tick = 1'b0;
        endcase
        if (slow && sel != ctp_pkg::CTP_SEL_EXT &&
            !(pwm && sel == ctp_pkg::CTP_SEL_SUB)) begin
            tick = sub8;
        end
        if (upper_control_reg_ff[2:0] == ctp_pkg::CTP_MODE_EVENT) begin
            tick = evt_fall;
        end
    end

    // register writes and counter next state
    always_comb begin
        nxt_lower_control_reg = lower_control_reg_ff;
        nxt_upper_control_reg = upper_control_reg_ff;
        nxt_cfg      = cfg_ff;
        nxt_period   = period_ff;
        nxt_duty_buf = duty_buf_ff;
        nxt_duty_act = duty_act_ff;
        nxt_cnt_lo   = cnt_lo_ff;
        nxt_cnt_hi   = cnt_hi_ff;
        nxt_tff      = tff_ff;
        nxt_irq      = 1'b0;
        if (wr) begin
            case (paddr_i)
                `CTP_OFS_LOWER_CTRL: nxt_lower_control_reg = pwdata_i[7:0];
                `CTP_OFS_UPPER_CTRL: begin
                    nxt_upper_control_reg = pwdata_i[7:0];
                    // init write while stopped moves pin
                    if (!run) begin
                        nxt_tff = pwdata_i[`CTP_UC_FFINIT_BIT];
                    end
                end
                `CTP_OFS_PERIOD_LO:  nxt_period[7:0]  = pwdata_i[7:0];
                `CTP_OFS_PERIOD_HI:  nxt_period[15:8] = pwdata_i[7:0];
                `CTP_OFS_DUTY_LO:    nxt_duty_buf[7:0]  = pwdata_i[7:0];
                `CTP_OFS_DUTY_HI:    nxt_duty_buf[15:8] = pwdata_i[7:0];
                `CTP_OFS_CONFIG:     nxt_cfg = pwdata_i[1:0];
                default: ;
            endcase
        end
        // stopped or non-pwm: duty taken at once
        if (!(run && pwm)) begin
            nxt_duty_act = nxt_duty_buf;
        end
        if (!run) begin
            nxt_cnt_lo = 8'h00;
            nxt_cnt_hi = 8'h00;
        end else if (tick && pwm) begin
            // toggle on duty match and overflow
            nxt_tff = tff_ff ^ (cnt == duty_act_ff) ^ ovf;
            if (ovf) begin
                nxt_cnt_lo   = 8'h00;
                nxt_cnt_hi   = 8'h00;
                nxt_irq      = 1'b1;
                nxt_duty_act = duty_buf_ff;
            end else begin
                nxt_cnt_lo = cnt_lo_ff + 8'h01;
                nxt_cnt_hi = cnt_hi_ff + {7'h00, &cnt_lo_ff};
            end
        end else if (tick) begin
            if (hit) begin
                nxt_cnt_lo = 8'h00;
                nxt_cnt_hi = 8'h00;
                nxt_irq    = 1'b1;
            end else begin
                nxt_cnt_lo = cnt_lo_ff + 8'h01;
                nxt_cnt_hi = cnt_hi_ff + {7'h00, &cnt_lo_ff};
            end
        end
    end

    // core state registers
    always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lower_control_reg_ff <= `CTP_RST_CTRL;
            upper_control_reg_ff <= `CTP_RST_CTRL;
            cfg_ff               <= 2'h0;
            period_ff            <= `CTP_RST_CMP;
            duty_buf_ff          <= `CTP_RST_CMP;
            duty_act_ff          <= `CTP_RST_CMP;
            cnt_lo_ff            <= 8'h00;
            cnt_hi_ff            <= 8'h00;
            tff_ff               <= 1'b0;
            pwm_out_n_o          <= 1'b1;
            match_overflow_irq_o <= 1'b0;
        end else begin
            lower_control_reg_ff <= nxt_lower_control_reg;
            upper_control_reg_ff <= nxt_upper_control_reg;
            cfg_ff               <= nxt_cfg;
            period_ff            <= nxt_period;
            duty_buf_ff          <= nxt_duty_buf;
            duty_act_ff          <= nxt_duty_act;
            cnt_lo_ff            <= nxt_cnt_lo;
            cnt_hi_ff            <= nxt_cnt_hi;
            tff_ff               <= nxt_tff;
            pwm_out_n_o          <= !nxt_tff;
            match_overflow_irq_o <= nxt_irq;
        end
    end

    // apb answer: data latched in setup, ready in first access cycle
    always_comb begin
        nxt_pready  = psel_i && !penable_i;
        nxt_pslverr = 1'b0;
        nxt_prdata  = 32'h0000_0000;
        case (paddr_i)
            `CTP_OFS_LOWER_CTRL: nxt_prdata[7:0] = lower_control_reg_ff;
            `CTP_OFS_UPPER_CTRL: nxt_prdata[7:0] = upper_control_reg_ff;
            `CTP_OFS_PERIOD_LO:  nxt_prdata[7:0] = period_ff[7:0];
            `CTP_OFS_PERIOD_HI:  nxt_prdata[7:0] = period_ff[15:8];
            `CTP_OFS_DUTY_LO:    nxt_prdata[7:0] = duty_act_ff[7:0];
            `CTP_OFS_DUTY_HI:    nxt_prdata[7:0] = duty_act_ff[15:8];
            `CTP_OFS_COUNT:      nxt_prdata[15:0] = cnt;
            `CTP_OFS_CONFIG:     nxt_prdata[1:0] = cfg_ff;
            default:             nxt_pslverr = nxt_pready;
        endcase
    end

    // apb answer registers
    always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= nxt_prdata;
            pready_o  <= nxt_pready;
            pslverr_o <= nxt_pslverr;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_ff);

    run_gate_a: assert property (
        !run |=> cnt == 16'h0000 && !match_overflow_irq_o)
        else $error("counter moved while stopped");
    tmr_match_a: assert property (
        run && !pwm && tick && hit |=> cnt == 16'h0000
        ##0 match_overflow_irq_o)
        else $error("timer match did not clear and interrupt");
    evt_count_a: assert property (
        run && upper_control_reg_ff[2:0] == ctp_pkg::CTP_MODE_EVENT
        && evt_fall && !hit && !wr |=> cnt == $past(cnt) + 16'h0001)
        else $error("event edge not counted");
    pwm_pin_a: assert property (
        pwm_out_n_o == !tff_ff)
        else $error("pwm pin not inverse of flip-flop");
    pwm_ovf_a: assert property (
        run && pwm && tick && ovf && duty_act_ff != `CTP_CNT_MAX
        |=> tff_ff != $past(tff_ff) && cnt == 16'h0000
        && match_overflow_irq_o)
        else $error("overflow did not toggle and clear");
    duty_load_a: assert property (
        run && pwm && tick && ovf |=> duty_act_ff == $past(duty_buf_ff))
        else $error("duty not loaded at overflow");
    duty_hold_a: assert property (
        run && pwm && !(tick && ovf) && !wr |=> $stable(duty_act_ff))
        else $error("active duty changed mid period");
    stop_hold_a: assert property (
        !run && !wr ##1 !run && !wr |-> $stable(pwm_out_n_o))
        else $error("pin moved while stopped");
    apb_ready_a: assert property (
        psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("apb ready not a single access cycle");

    timer_match_c: cover property (run && !pwm && tick && hit);
    pwm_ovf_c: cover property (run && pwm && tick && ovf);
    pwm_duty_c: cover property (run && pwm && tick && cnt == duty_act_ff);
    event_c: cover property (run && evt_fall ##[1:20] match_overflow_irq_o);
endmodule

/* ctp_defines.svh */
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH

// register byte offsets on the apb
`define CTP_OFS_LOWER_CTRL   8'h00
`define CTP_OFS_UPPER_CTRL   8'h04
`define CTP_OFS_PERIOD_LO    8'h08
`define CTP_OFS_PERIOD_HI    8'h0C
`define CTP_OFS_DUTY_LO      8'h10
`define CTP_OFS_DUTY_HI      8'h14
`define CTP_OFS_COUNT        8'h18
`define CTP_OFS_CONFIG       8'h1C

// upper control fields
`define CTP_UC_RUN_BIT       3
`define CTP_UC_FFINIT_BIT    7
`define CTP_UC_MODE_LSB      0
// lower control fields
`define CTP_LC_SEL_LSB       4
`define CTP_LC_FFINIT_BIT    7
// config fields
`define CTP_CFG_PSEL_BIT     0
`define CTP_CFG_SLOW_BIT     1

// reset values and counter maximum
`define CTP_RST_CTRL         8'h00
`define CTP_RST_CMP          16'hFFFF
`define CTP_CNT_MAX          16'hFFFF

// main clock and sub clock rates
`define CTP_CLK_HZ           100000000
`define CTP_SUB_HZ           32768
`define CTP_SUB_DIV          (`CTP_CLK_HZ / `CTP_SUB_HZ)

`endif

/* ctp_pkg.sv */
package ctp_pkg;

    // counting modes, upper control bits 2:0
    typedef enum logic [2:0] {
        CTP_MODE_TIMER = 3'h0,
        CTP_MODE_EVENT = 3'h1,
        CTP_MODE_PWM   = 3'h3
    } ctp_mode_e;

    // source clock select, lower control bits 6:4
    typedef enum logic [2:0] {
        CTP_SEL_DIV11 = 3'h0,
        CTP_SEL_DIV7  = 3'h1,
        CTP_SEL_DIV5  = 3'h2,
        CTP_SEL_DIV3  = 3'h3,
        CTP_SEL_SUB   = 3'h4,
        CTP_SEL_DIV1  = 3'h5,
        CTP_SEL_MAIN  = 3'h6,
        CTP_SEL_EXT   = 3'h7
    } ctp_sel_e;

endpackage

/* ctp_prescaler.sv */
`timescale 1ns/10ps
`include "ctp_defines.svh"

module ctp_prescaler #(
    parameter int SUB_DIV = `CTP_SUB_DIV
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      t1_o,
    output logic      t3_o,
    output logic      t5_o,
    output logic      t7_o,
    output logic      t11_o,
    output logic      sub_o,
    output logic      sub8_o
);
    logic [10:0] div_ff;
    logic [15:0] sub_cnt_ff;
    logic [2:0]  sub8_ff;
    logic        sub_hit;

    // sub clock tick when the integer divider wraps
    assign sub_hit = (sub_cnt_ff == 16'(SUB_DIV - 1));

    // free running dividers, one-cycle tick per period
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ff     <= 11'h000;
            sub_cnt_ff <= 16'h0000;
            sub8_ff    <= 3'h0;
            t1_o       <= 1'b0;
            t3_o       <= 1'b0;
            t5_o       <= 1'b0;
            t7_o       <= 1'b0;
            t11_o      <= 1'b0;
            sub_o      <= 1'b0;
            sub8_o     <= 1'b0;
        end else begin
            div_ff     <= div_ff + 11'h001;
            sub_cnt_ff <= sub_hit ? 16'h0000 : sub_cnt_ff + 16'h0001;
            if (sub_hit) begin
                sub8_ff <= sub8_ff + 3'h1;
            end
            t1_o   <= &div_ff[0:0];
            t3_o   <= &div_ff[2:0];
            t5_o   <= &div_ff[4:0];
            t7_o   <= &div_ff[6:0];
            t11_o  <= &div_ff[10:0];
            sub_o  <= sub_hit;
            sub8_o <= sub_hit && (&sub8_ff);
        end
    end
endmodule

/* ctp_event_sync.sv */
`timescale 1ns/10ps

module ctp_event_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      fall_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic lvl_ff;

    // three-stage sync, level accepted once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff  <= 1'b1;
            s2_ff  <= 1'b1;
            s3_ff  <= 1'b1;
            lvl_ff <= 1'b1;
            fall_o <= 1'b0;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                lvl_ff <= s3_ff;
            end
            fall_o <= (s2_ff == s3_ff) && lvl_ff && !s3_ff;
        end
    end
endmodule

/* ctp_event_src.sv */
`timescale 1ns/10ps

module ctp_event_src (
    input  wire logic clk_i,
    output logic      pin_o
);
    // idle high, so no stray fall is seen
    initial pin_o = 1'b1;

    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (6) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (6) @(posedge clk_i);
            pin_o <= 1'b1;
        end
        repeat (8) @(posedge clk_i);
    endtask
endmodule

/* ctp_timer_tb.sv */
`timescale 1ns/10ps
`include "ctp_defines.svh"

module ctp_timer_tb;
    localparam int SUBD = 4;
    // timer table: config, select, period, irq spacing
    localparam logic [7:0]  TCFG [8] = '{0, 0, 0, 0, 1, 2, 0, 0};
    localparam logic [2:0]  TSEL [8] = '{0, 1, 2, 3, 0, 3, 3, 3};
    localparam logic [15:0] TPER [8] = '{0, 0, 0, 0, 0, 0, 3, 16'h0101};
    localparam int          TGAP [8] = '{2048, 128, 32, 8, SUBD * 8,
                                         SUBD * 8, 32, 2064};
    logic        clk, resetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pwm_n, irq, err, evt;
    int          errors, comparisons, cyc, t0;

    ctp_timer #(.SUB_DIV(SUBD)) dut_u (
        .ref_clk_i(clk), .resetn_i(resetn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .event_input_pin_i(evt),
        .pwm_out_n_o(pwm_n), .match_overflow_irq_o(irq)
    );
    ctp_event_src src_u (.clk_i(clk), .pin_o(evt));

    // clock
    always #5 clk = ~clk;

    // cycle count and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            errors = errors + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no limit here: pready or the bench timeout ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic set16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(lo + 8'h04, v[15:8]);
    endtask

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < lim);
        chk({31'h0, irq}, 32'h1);
    endtask

    task automatic pin_is(input int wait_n, input logic e);
        repeat (wait_n) @(posedge clk);
        chk({31'h0, pwm_n}, {31'h0, e});
    endtask

    // count gained over gap plus three cycles between two reads
    task automatic rate(input int gap, input logic [31:0] e);
        logic [31:0] c0;
        apb(1'b0, `CTP_OFS_COUNT, 32'h0);
        c0 = rd;
        repeat (gap) @(posedge clk);
        apb(1'b0, `CTP_OFS_COUNT, 32'h0);
        chk(rd - c0, e);
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        comparisons = 0;
        cyc = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        // reset values and an unmapped place
        pin_is(0, 1'b1);
        rdchk(`CTP_OFS_UPPER_CTRL, 32'h0);
        rdchk(`CTP_OFS_PERIOD_HI, 32'hFF);
        rdchk(`CTP_OFS_DUTY_LO, 32'hFF);
        rdchk(`CTP_OFS_CONFIG, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // configured but not started: no counting
        wr(`CTP_OFS_LOWER_CTRL, 8'h30);
        repeat (50) @(posedge clk);
        rdchk(`CTP_OFS_COUNT, 32'h0);
        $display("reset test done");
        // timer mode: prescale choices, match clear, stage carry
        for (int i = 0; i < 8; i++) begin
            wr(`CTP_OFS_UPPER_CTRL, 8'h00);
            wr(`CTP_OFS_CONFIG, TCFG[i]);
            wr(`CTP_OFS_LOWER_CTRL, {1'b0, TSEL[i], 4'h0});
            set16(`CTP_OFS_PERIOD_LO, TPER[i]);
            wr(`CTP_OFS_UPPER_CTRL, 8'h08);
            wait_irq(5000);
            t0 = cyc;
            wait_irq(5000);
            chk(cyc - t0, TGAP[i]);
        end
        wr(`CTP_OFS_UPPER_CTRL, 8'h00);
        wr(`CTP_OFS_CONFIG, 8'h00);
        $display("timer test done");
        // event mode: falls count, match clears, counting resumes
        set16(`CTP_OFS_PERIOD_LO, 16'h0002);
        wr(`CTP_OFS_UPPER_CTRL, 8'h09);
        src_u.pulse(2);
        rdchk(`CTP_OFS_COUNT, 32'h2);
        src_u.pulse(1);
        rdchk(`CTP_OFS_COUNT, 32'h0);
        src_u.pulse(1);
        rdchk(`CTP_OFS_COUNT, 32'h1);
        // pwm counted from the event pin
        wr(`CTP_OFS_UPPER_CTRL, 8'h00);
        wr(`CTP_OFS_LOWER_CTRL, 8'h70);
        wr(`CTP_OFS_UPPER_CTRL, 8'h0B);
        src_u.pulse(3);
        rdchk(`CTP_OFS_COUNT, 32'h3);
        $display("event test done");
        // pwm from main clock: stopped duty write goes straight in
        wr(`CTP_OFS_UPPER_CTRL, 8'h03);
        wr(`CTP_OFS_LOWER_CTRL, 8'h60);
        set16(`CTP_OFS_DUTY_LO, 16'h0010);
        rdchk(`CTP_OFS_DUTY_LO, 32'h10);
        wr(`CTP_OFS_UPPER_CTRL, 8'h83);
        pin_is(2, 1'b0);
        wr(`CTP_OFS_UPPER_CTRL, 8'h03);
        pin_is(2, 1'b1);
        wr(`CTP_OFS_UPPER_CTRL, 8'h0B);
        pin_is(40, 1'b0);
        set16(`CTP_OFS_DUTY_LO, 16'h0020);
        rdchk(`CTP_OFS_DUTY_LO, 32'h10);
        wait_irq(70000);
        pin_is(0, 1'b1);
        rdchk(`CTP_OFS_DUTY_LO, 32'h20);
        pin_is(20, 1'b1);
        pin_is(15, 1'b0);
        // stop holds the pin; a later init write sets it
        wr(`CTP_OFS_UPPER_CTRL, 8'h03);
        pin_is(3, 1'b0);
        rdchk(`CTP_OFS_COUNT, 32'h0);
        wr(`CTP_OFS_UPPER_CTRL, 8'h03);
        pin_is(2, 1'b1);
        // pwm only sources: main over two, sub clock; none in timer mode
        wr(`CTP_OFS_LOWER_CTRL, 8'h50);
        wr(`CTP_OFS_UPPER_CTRL, 8'h0B);
        rate(7, 32'h5);
        wr(`CTP_OFS_UPPER_CTRL, 8'h03);
        wr(`CTP_OFS_LOWER_CTRL, 8'h40);
        wr(`CTP_OFS_UPPER_CTRL, 8'h0B);
        rate(5 * SUBD - 3, 32'h5);
        wr(`CTP_OFS_UPPER_CTRL, 8'h00);
        wr(`CTP_OFS_UPPER_CTRL, 8'h08);
        rate(5 * SUBD - 3, 32'h0);
        wr(`CTP_OFS_UPPER_CTRL, 8'h00);
        $display("pwm test done");
        print_verdict();
    end
endmodule
